// file: src/ptk_consts.vh
// Constants for the periodic tick down counter
`ifndef PTK_CONSTS_VH
`define PTK_CONSTS_VH
`define PTK_ADDR_W        12
`define PTK_CNT_W         24
`define PTK_OFF_CTRL      12'h000
`define PTK_OFF_RELOAD    12'h004
`define PTK_OFF_CURRENT   12'h008
`define PTK_OFF_STATUS    12'h00C
`define PTK_OFF_INT_EN    12'h010
`define PTK_OFF_INT_CLR   12'h014
`define PTK_OFF_ACK       12'h018
`define PTK_BIT_ENABLE    0
`define PTK_BIT_TICK_IE   1
`define PTK_BIT_TICK      0
`define PTK_RST_CTRL      2'h0
`define PTK_RST_RELOAD    24'h000000
`define PTK_RST_COUNT     24'h000000
`define PTK_HTRANS_NONSEQ 2'h2
`define PTK_HTRANS_SEQ    2'h3
`endif

// file: src/ptk_down_counter.v
// Down counter with reload and forced clear
`timescale 1ns/1ns
`default_nettype none
`include "ptk_consts.vh"
module ptk_down_counter (
  // Clock and reset
  input  wire                   hclk,
  input  wire                   hresetn,
  // Control
  input  wire                   run,
  input  wire                   force_clear,
  input  wire [`PTK_CNT_W-1:0]  reload_period,
  // State
  output reg  [`PTK_CNT_W-1:0]  count_ff,
  output reg                    wrap_ff
);
  reg [`PTK_CNT_W-1:0] nxt_count;
  reg                  nxt_wrap;

  always @* begin
    nxt_count = count_ff;
    nxt_wrap  = 1'b0;
    if (force_clear) begin
      nxt_count = `PTK_RST_COUNT;
    end else if (run) begin
      if (count_ff == `PTK_RST_COUNT) begin
        nxt_count = reload_period;
        nxt_wrap  = 1'b1;
      end else begin
        nxt_count = count_ff - 1'b1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= `PTK_RST_COUNT;
      wrap_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      wrap_ff  <= nxt_wrap;
    end
  end
endmodule // ptk_down_counter
`default_nettype wire

// file: src/ptk_irq_status.v
// Sticky tick status with enable gating and clear
`timescale 1ns/1ns
`default_nettype none
module ptk_irq_status (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Events and controls
  input  wire tick,
  input  wire clear,
  input  wire int_en,
  // Results
  output reg  status_ff,
  output reg  irq_ff
);
  wire nxt_status;
  // Set wins over a same-cycle clear
  assign nxt_status = tick | (status_ff & ~clear);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= nxt_status & int_en;
    end
  end
endmodule // ptk_irq_status
`default_nettype wire

// file: src/ptk_timer.v
// Periodic tick timer with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ptk_consts.vh"
// Contract
// - period 1 to 16777216, 24-bit reload
// - read value lies in period-1..0
// - tick spacing equals programmed period
// - enable resumes from current count
// - current write clears count, then reloads
// - new period applies at next reload
// - disable halts counting and ticks
// - rollover raises tick event
// - interrupt enable gates forwarding
// - handler entry clears pending tick
module ptk_timer (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Processor side
  input  wire        handler_entry,
  output reg         tick_irq
);
  reg  [1:0]            ctrl_ff;
  reg  [`PTK_CNT_W-1:0] reload_ff;
  reg                   int_en_ff;
  reg                   wr_pend_ff;
  reg  [`PTK_ADDR_W-1:0] wr_addr_ff;
  reg  [1:0]            nxt_ctrl;
  reg  [`PTK_CNT_W-1:0] nxt_reload;
  reg                   nxt_int_en;
  reg  [31:0]           nxt_rdata;
  reg                   clr_status;
  reg                   clr_count;
  wire [`PTK_CNT_W-1:0] count;
  wire                  wrap;
  wire                  status;
  wire                  irq_int;
  wire                  addr_ok;
  wire [`PTK_ADDR_W-1:0] a_off;

  // Only NONSEQ/SEQ transfers with hready high are taken
  function is_xfer;
    input [1:0] tr;
    input       s;
    input       rdy;
    begin
      is_xfer = s & rdy & (tr == `PTK_HTRANS_NONSEQ || tr == `PTK_HTRANS_SEQ);
    end
  endfunction

  assign addr_ok = is_xfer(htrans, hsel, hready);
  assign a_off   = haddr[`PTK_ADDR_W-1:0];

  ptk_down_counter u_cnt (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (ctrl_ff[`PTK_BIT_ENABLE]),
    .force_clear   (clr_count),
    .reload_period (reload_ff),
    .count_ff      (count),
    .wrap_ff       (wrap)
  );

  ptk_irq_status u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (wrap),
    .clear     (clr_status),
    .int_en    (int_en_ff & ctrl_ff[`PTK_BIT_TICK_IE]),
    .status_ff (status),
    .irq_ff    (irq_int)
  );

  // Data-phase writes: hwdata valid one cycle after address
  always @* begin
    nxt_ctrl   = ctrl_ff;
    nxt_reload = reload_ff;
    nxt_int_en = int_en_ff;
    clr_count  = 1'b0;
    clr_status = handler_entry;
    if (wr_pend_ff) begin
      case (wr_addr_ff)
        `PTK_OFF_CTRL:    nxt_ctrl = hwdata[1:0];
        // 24-bit field holds period minus one
        `PTK_OFF_RELOAD:  nxt_reload = hwdata[`PTK_CNT_W-1:0];
        `PTK_OFF_CURRENT: clr_count = 1'b1;
        `PTK_OFF_INT_EN:  nxt_int_en = hwdata[`PTK_BIT_TICK];
        `PTK_OFF_INT_CLR: clr_status = clr_status | hwdata[`PTK_BIT_TICK];
        `PTK_OFF_ACK:     clr_status = 1'b1;
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
  end

  // Read mux; unmapped reads return zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (a_off)
      `PTK_OFF_CTRL:    nxt_rdata = {30'h00000000, ctrl_ff};
      `PTK_OFF_RELOAD:  nxt_rdata = {8'h00, reload_ff};
      `PTK_OFF_CURRENT: nxt_rdata = {8'h00, count};
      `PTK_OFF_STATUS:  nxt_rdata = {31'h00000000, status};
      `PTK_OFF_INT_EN:  nxt_rdata = {31'h00000000, int_en_ff};
      default:          nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff    <= `PTK_RST_CTRL;
      reload_ff  <= `PTK_RST_RELOAD;
      int_en_ff  <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= {`PTK_ADDR_W{1'b0}};
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      tick_irq   <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      reload_ff  <= nxt_reload;
      int_en_ff  <= nxt_int_en;
      wr_pend_ff <= addr_ok & hwrite;
      wr_addr_ff <= a_off;
      if (addr_ok & ~hwrite) begin
        hrdata <= nxt_rdata;
      end
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      tick_irq   <= irq_int;
    end
  end
endmodule // ptk_timer
`default_nettype wire

// file: tb/ptk_timer_chk.sv
// Port checker for the tick timer
`timescale 1ns/1ns
`default_nettype none
`include "ptk_consts.vh"
module ptk_timer_chk (
  // Bus and processor side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        handler_entry,
  input wire logic        tick_irq
);
  logic take;
  logic rd_ff, cur_ff, unm_ff, wr_ff;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rd_ff, cur_ff, unm_ff, wr_ff} <= 4'h0;
    end else begin
      rd_ff  <= take && !hwrite;
      cur_ff <= take && !hwrite && haddr[11:0] == `PTK_OFF_CURRENT;
      unm_ff <= take && !hwrite && haddr[11:0] >= 12'h01C;
      wr_ff  <= take && hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_count_width: assert property (cur_ff |-> hrdata[31:24] == 8'h00)
    else $error("count too wide");
  a_read_hold: assert property (!rd_ff |-> $stable(hrdata)) else $error("read moved");
  a_unmapped_zero: assert property (unm_ff |-> hrdata == 32'h0) else $error("unmapped");
  a_handler_clear: assert property (handler_entry && tick_irq |-> ##2 !tick_irq)
    else $error("irq kept");
  // Clears reach the pin two edges late
  a_irq_sticky: assert property (tick_irq && !handler_entry && !$past(handler_entry) &&
    !wr_ff && !$past(wr_ff) && !$past(wr_ff, 2) |=> tick_irq)
    else $error("irq lost");
  a_reset_quiet: assert property ($rose(hresetn) |-> !tick_irq) else $error("irq at reset");
  cover property (tick_irq && handler_entry);
  cover property (cur_ff);
  cover property ($rose(tick_irq));
endmodule // ptk_timer_chk
bind ptk_timer ptk_timer_chk u_chk (.*);
`default_nettype wire

// file: tb/ptk_timer_tb_top.sv
// Self-checking bench for the tick timer
`timescale 1ns/1ns
`default_nettype none
`include "ptk_consts.vh"
module ptk_timer_tb_top;
  logic        hclk = 0, hresetn = 0, hwrite = 0, handler_entry = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, tick_irq;
  int          err_count = 0, n_compared = 0, n, m, t;
  int          cyc = 0, last_rise = 0, rise_gap = 0, n_rise = 0;
  logic        irq_q = 0;
  always #20 hclk = ~hclk;
  // Rises timed on the settled falling edge
  always @(negedge hclk) begin
    cyc <= cyc + 1;
    irq_q <= tick_irq;
    if (tick_irq === 1'b1 && irq_q !== 1'b1) begin
      rise_gap <= cyc - last_rise;
      last_rise <= cyc;
      n_rise <= n_rise + 1;
    end
  end
  ptk_timer u_ptk_timer (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .handler_entry(handler_entry),
    .tick_irq(tick_irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wirq(output int c);
    int k;
    k = n_rise;
    c = 0;
    while (n_rise == k && c < 5000) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic ack;
    handler_entry <= 1'b1;
    @(posedge hclk) handler_entry <= 1'b0;
    @(posedge hclk);
  endtask
  // Spacing between the last two interrupt rises
  task automatic gap(output int c);
    ack;
    wirq(c);
    c = rise_gap;
  endtask
  task automatic results;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000 err_count++;
    results;
  end
  initial begin
    void'($urandom(67101));
    // Long enough for bus traffic between ticks
    n = 10 + $urandom % 23;
    m = 10 + $urandom % 23;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, `PTK_OFF_CURRENT, 0); chk(r, 0);
    bus(0, 12'h01C, 0); chk(r, 0);
    bus(1, `PTK_OFF_RELOAD, n - 1);
    bus(1, `PTK_OFF_INT_EN, 1);
    bus(1, `PTK_OFF_CTRL, 3);
    wirq(t); gap(t); chk(t, n);
    bus(0, `PTK_OFF_CURRENT, 0); chk(r < n, 1);
    bus(1, `PTK_OFF_RELOAD, m - 1);
    gap(t); chk(t, n);
    gap(t); chk(t, m);
    bus(1, `PTK_OFF_CTRL, 2);
    ack; bus(0, `PTK_OFF_CURRENT, 0); t = r;
    repeat (2 * m) @(posedge hclk);
    bus(0, `PTK_OFF_CURRENT, 0); chk(r, t);
    chk(tick_irq, 0);
    t = r;
    bus(1, `PTK_OFF_CTRL, 3); bus(0, `PTK_OFF_CURRENT, 0); chk(r, t);
    bus(1, `PTK_OFF_CTRL, 2); ack;
    bus(1, `PTK_OFF_CURRENT, $urandom); bus(0, `PTK_OFF_CURRENT, 0); chk(r, 0);
    bus(1, `PTK_OFF_CTRL, 3); wirq(t); chk(t < 8, 1);
    bus(1, `PTK_OFF_INT_EN, 0);
    repeat (m) @(posedge hclk);
    chk(tick_irq, 0);
    bus(1, `PTK_OFF_CTRL, 0); bus(0, `PTK_OFF_STATUS, 0); chk(r, 1);
    bus(1, `PTK_OFF_INT_CLR, 1); bus(0, `PTK_OFF_STATUS, 0); chk(r, 0);
    results;
  end
endmodule // ptk_timer_tb_top
`default_nettype wire
